// ==== rtl/sxs_consts.svh ====
// constants for the subtract / xor / swap / sleep execution block
`ifndef SXS_CONSTS_SVH
`define SXS_CONSTS_SVH

`define SXS_DIR_A_SEL    7'h05
`define SXS_DIR_B_SEL    7'h06
`define SXS_DIR_C_SEL    7'h07
`define SXS_WDT_CLEAR    8'h00
`define SXS_PRE_CLEAR    8'h00
`define SXS_PRE_LAST     8'hFF
`define SXS_ACC_RESET    8'h00
`define SXS_DIR_RESET    8'hFF
`define SXS_RF_RESET     8'h00

`endif

// ==== rtl/sxs_pkg.sv ====
// types shared by the execution block and the bench
package sxs_pkg;

  // operation codes presented with each request
  typedef enum logic [3:0] {
    SXS_OP_NOP       = 4'h0,
    SXS_OP_LIT_SUB   = 4'h1,
    SXS_OP_REG_SUB   = 4'h2,
    SXS_OP_REG_SUB_B = 4'h3,
    SXS_OP_NIB_EX    = 4'h4,
    SXS_OP_LIT_XOR   = 4'h5,
    SXS_OP_REG_XOR   = 4'h6,
    SXS_OP_DIR_LOAD  = 4'h7,
    SXS_OP_SLEEP     = 4'h8
  } sxs_op_t;

  // one decoded instruction
  typedef struct packed {
    sxs_op_t    op;
    logic [7:0] lit;
    logic [6:0] fidx;
    logic       dest;
  } sxs_req_t;

  // status bits; the two power bits are active low
  typedef struct packed {
    logic carry;
    logic nibble_borrow_inverse;
    logic zero;
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } sxs_flags_t;

  // port direction registers
  typedef struct packed {
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
  } sxs_dirs_t;

endpackage

// ==== rtl/sxs_sub8.sv ====
// 8-bit two's complement subtractor with carry and nibble carry
`timescale 1ns/10ps
`default_nettype none
module sxs_sub8 (
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       carry_in,
  output logic      [7:0] diff,
  output logic            carry_out,
  output logic            nibble_carry_out
);
  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // add the inverted subtrahend; carry out high means no borrow
  assign full_sum         = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
  assign low_sum          = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
  assign diff             = full_sum[7:0];
  assign carry_out        = full_sum[8];
  assign nibble_carry_out = low_sum[4];
endmodule // sxs_sub8
`default_nettype wire

// ==== rtl/sxs_regfile.sv ====
// register file: combinational read, one clocked write port
`timescale 1ns/10ps
`default_nettype none
`include "sxs_consts.svh"
module sxs_regfile #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          clk_en,
  input  wire logic [AW-1:0] rd_idx,
  output logic      [7:0]    rd_data,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [7:0]    wr_data
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } sxs_rf_state_t;

  sxs_rf_state_t st_reg;
  sxs_rf_state_t st_next;

  // read is combinational so an operation finishes in its own cycle
  assign rd_data = st_reg.mem[rd_idx];

  // write port
  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.mem[wr_idx] = wr_data;
    end
  end

  // clear at reset; hold while the clock enable is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end
endmodule // sxs_regfile
`default_nettype wire

// ==== rtl/sxs_exec.sv ====
// execution unit for subtract, xor, nibble exchange, direction load and sleep
`timescale 1ns/10ps
`default_nettype none
`include "sxs_consts.svh"
module sxs_exec
  import sxs_pkg::*;
#(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       req_valid,
  input  wire sxs_req_t   req,
  input  wire logic       wake_pin,
  input  wire logic       wdt_enable,
  output logic      [7:0] acc_out,
  output sxs_flags_t      flags_out,
  output sxs_dirs_t       dirs_out,
  output logic      [7:0] wdt_count,
  output logic      [7:0] wdt_prescale,
  output logic            asleep,
  output logic            osc_run,
  output logic            done,
  output logic            illegal,
  output logic      [7:0] last_result
);

  // whole state of the unit
  typedef struct packed {
    logic [7:0] acc;
    sxs_flags_t flags;
    sxs_dirs_t  dirs;
    logic [7:0] wdt;
    logic [7:0] pre;
    logic       asleep;
    logic       osc_run;
    logic       done;
    logic       illegal;
    logic [7:0] result;
    logic       wake_s1;
    logic       wake_s2;
  } sxs_exec_state_t;

  sxs_exec_state_t st_reg;
  sxs_exec_state_t st_next;

  // datapath wires
  logic       go;
  logic [7:0] rf_rdata;
  logic       rf_we;
  logic [7:0] rf_wdata;
  logic [7:0] sub_min;
  logic       sub_cin;
  logic [7:0] sub_diff;
  logic       sub_c;
  logic       sub_dc;
  logic [7:0] res;
  logic       res_valid;
  logic       res_to_rf;
  logic       upd_sub_flags;
  logic       upd_zero;

  // a request is only taken while awake; the halted core fetches nothing
  assign go = req_valid && !st_reg.asleep;

  sxs_regfile #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rf (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .rd_idx  (req.fidx),
    .rd_data (rf_rdata),
    .wr_en   (rf_we),
    .wr_idx  (req.fidx),
    .wr_data (rf_wdata)
  );

  // minuend select
  // literal ops subtract from the literal, register ops from the register
  assign sub_min = (req.op == SXS_OP_LIT_SUB) ? req.lit : rf_rdata;

  // borrow in
  // the stored carry is the inverted borrow, so it feeds carry-in directly
  assign sub_cin = (req.op == SXS_OP_REG_SUB_B) ? st_reg.flags.carry : 1'b1;

  sxs_sub8 u_sub (
    .minuend          (sub_min),
    .subtrahend       (st_reg.acc),
    .carry_in         (sub_cin),
    .diff             (sub_diff),
    .carry_out        (sub_c),
    .nibble_carry_out (sub_dc)
  );

  // operation decode: result, where it goes and which flags move
  always_comb begin
    res           = 8'h00;
    res_valid     = 1'b0;
    res_to_rf     = 1'b0;
    upd_sub_flags = 1'b0;
    upd_zero      = 1'b0;
    if (go) begin
      unique case (req.op)
        SXS_OP_LIT_SUB: begin
          res           = sub_diff;
          res_valid     = 1'b1;
          upd_sub_flags = 1'b1;
          upd_zero      = 1'b1;
        end
        SXS_OP_REG_SUB, SXS_OP_REG_SUB_B: begin
          res           = sub_diff;
          res_valid     = 1'b1;
          res_to_rf     = req.dest;
          upd_sub_flags = 1'b1;
          upd_zero      = 1'b1;
        end
        SXS_OP_NIB_EX: begin
          res       = {rf_rdata[3:0], rf_rdata[7:4]};
          res_valid = 1'b1;
          res_to_rf = req.dest;
        end
        SXS_OP_LIT_XOR: begin
          res       = st_reg.acc ^ req.lit;
          res_valid = 1'b1;
          upd_zero  = 1'b1;
        end
        SXS_OP_REG_XOR: begin
          res       = st_reg.acc ^ rf_rdata;
          res_valid = 1'b1;
          res_to_rf = req.dest;
          upd_zero  = 1'b1;
        end
        SXS_OP_NOP, SXS_OP_DIR_LOAD, SXS_OP_SLEEP: begin
          res_valid = 1'b0;
        end
        default: begin
          res_valid = 1'b0;
        end
      endcase
    end
  end

  assign rf_we    = res_valid && res_to_rf;
  assign rf_wdata = res;

  // next state
  always_comb begin
    st_next         = st_reg;
    st_next.done    = 1'b0;
    st_next.illegal = 1'b0;
    // wake pin is asynchronous; only the second stage is looked at
    st_next.wake_s1 = wake_pin;
    st_next.wake_s2 = st_reg.wake_s1;

    // watchdog prescaler and counter keep running, in sleep as well
    if (wdt_enable) begin
      st_next.pre = st_reg.pre + 8'h01;
      if (st_reg.pre == `SXS_PRE_LAST) begin
        st_next.wdt = st_reg.wdt + 8'h01;
      end
    end

    // leave sleep on a synchronised wake level
    if (st_reg.asleep && st_reg.wake_s2) begin
      st_next.asleep  = 1'b0;
      st_next.osc_run = 1'b1;
    end

    if (go) begin
      st_next.done = 1'b1;
      unique case (req.op)
        SXS_OP_DIR_LOAD: begin
          if (req.fidx == `SXS_DIR_A_SEL) begin
            st_next.dirs.port_a_direction = st_reg.acc;
          end else if (req.fidx == `SXS_DIR_B_SEL) begin
            st_next.dirs.port_b_direction = st_reg.acc;
          end else if (req.fidx == `SXS_DIR_C_SEL) begin
            st_next.dirs.port_c_direction = st_reg.acc;
          end else begin
            st_next.illegal = 1'b1; // no such direction register
          end
        end
        SXS_OP_SLEEP: begin
          st_next.wdt     = `SXS_WDT_CLEAR;
          st_next.pre     = `SXS_PRE_CLEAR;
          st_next.flags.powerdown_flag_n = 1'b0;
          st_next.flags.timeout_flag_n   = 1'b1;
          st_next.asleep  = 1'b1;
          st_next.osc_run = 1'b0;
        end
        SXS_OP_NOP, SXS_OP_LIT_SUB, SXS_OP_REG_SUB, SXS_OP_REG_SUB_B,
        SXS_OP_NIB_EX, SXS_OP_LIT_XOR, SXS_OP_REG_XOR: begin
          st_next.illegal = 1'b0;
        end
        default: begin
          st_next.illegal = 1'b1; // unknown code, treated as no operation
        end
      endcase
    end

    if (res_valid) begin
      st_next.result = res;
      if (!res_to_rf) begin
        st_next.acc = res;
      end
    end

    if (upd_sub_flags) begin
      st_next.flags.carry                 = sub_c;
      st_next.flags.nibble_borrow_inverse = sub_dc;
    end

    if (upd_zero) begin
      st_next.flags.zero = (res == 8'h00);
    end
  end

  // state register; clk_en freezes everything, including the synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg                              <= '0;
      st_reg.acc                          <= `SXS_ACC_RESET;
      st_reg.dirs.port_a_direction        <= `SXS_DIR_RESET;
      st_reg.dirs.port_b_direction        <= `SXS_DIR_RESET;
      st_reg.dirs.port_c_direction        <= `SXS_DIR_RESET;
      st_reg.flags.timeout_flag_n         <= 1'b1;
      st_reg.flags.powerdown_flag_n       <= 1'b1;
      st_reg.osc_run                      <= 1'b1;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign acc_out      = st_reg.acc;
  assign flags_out    = st_reg.flags;
  assign dirs_out     = st_reg.dirs;
  assign wdt_count    = st_reg.wdt;
  assign wdt_prescale = st_reg.pre;
  assign asleep       = st_reg.asleep;
  assign osc_run      = st_reg.osc_run;
  assign done         = st_reg.done;
  assign illegal      = st_reg.illegal;
  assign last_result  = st_reg.result;

  // checks tying results to operands one edge later

  AST_LIT_SUB: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_LIT_SUB)
    |=> (st_reg.acc == 8'($past(req.lit) - $past(st_reg.acc))))
    else $error("literal subtract result wrong");

  AST_REG_SUB: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_REG_SUB && !req.dest)
    |=> (st_reg.acc == 8'($past(rf_rdata) - $past(st_reg.acc))))
    else $error("register subtract result wrong");

  AST_DEST_RF: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.dest && (req.op == SXS_OP_REG_SUB || req.op == SXS_OP_NIB_EX))
    |-> rf_we ##1 $stable(st_reg.acc))
    else $error("destination bit not honoured");

  AST_BORROW: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_REG_SUB_B && !req.dest)
    |=> (st_reg.acc == 8'($past(rf_rdata) - $past(st_reg.acc) - {7'h00, !$past(st_reg.flags.carry)})))
    else $error("subtract with borrow wrong");

  AST_SWAP: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_NIB_EX && !req.dest)
    |=> (st_reg.acc == {$past(rf_rdata[3:0]), $past(rf_rdata[7:4])}) && $stable(st_reg.flags))
    else $error("nibble exchange wrong");

  AST_LIT_XOR: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_LIT_XOR)
    |=> (st_reg.acc == ($past(st_reg.acc) ^ $past(req.lit))) && $stable(st_reg.flags.carry))
    else $error("literal xor wrong");

  AST_REG_XOR: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_REG_XOR && req.dest)
    |=> (last_result == ($past(st_reg.acc) ^ $past(rf_rdata))) && $stable(st_reg.acc))
    else $error("register xor write-back wrong");

  AST_DIR_A: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_DIR_LOAD && req.fidx == `SXS_DIR_A_SEL)
    |=> (st_reg.dirs.port_a_direction == $past(st_reg.acc)) && $stable(st_reg.flags))
    else $error("direction load wrong");

  AST_SLEEP_WDT: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_SLEEP)
    |=> (st_reg.wdt == `SXS_WDT_CLEAR) && (st_reg.pre == `SXS_PRE_CLEAR))
    else $error("watchdog not cleared by sleep");

  AST_SLEEP_ST: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_SLEEP)
    |=> !st_reg.flags.powerdown_flag_n && st_reg.flags.timeout_flag_n && st_reg.asleep && !st_reg.osc_run)
    else $error("sleep status wrong");

  AST_CARRY: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_LIT_SUB)
    |=> (st_reg.flags.carry == ($past(st_reg.acc) <= $past(req.lit)))
     && (st_reg.flags.nibble_borrow_inverse == ($past(st_reg.acc[3:0]) <= $past(req.lit[3:0]))))
    else $error("carry or nibble carry wrong");

  AST_ZERO_DONE: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && go && req.op == SXS_OP_LIT_XOR)
    |=> done && (st_reg.flags.zero == (st_reg.acc == 8'h00)))
    else $error("zero flag or completion wrong");

endmodule // sxs_exec
`default_nettype wire

// ==== bench/tb_subtract_xor_swap_sleep_ops.sv ====
// self-checking bench for the subtract / xor / swap / sleep execution block
`timescale 1ns/10ps
`default_nettype none
module tb_subtract_xor_swap_sleep_ops
  import sxs_pkg::*;
;
  logic       clk;
  logic       reset_n;
  logic       clk_en;
  logic       req_valid;
  sxs_req_t   req;
  logic       wake_pin;
  logic       wdt_enable;
  logic [7:0] acc_out;
  sxs_flags_t flags_out;
  sxs_dirs_t  dirs_out;
  logic [7:0] wdt_count;
  logic [7:0] wdt_prescale;
  logic       asleep;
  logic       osc_run;
  logic       done;
  logic       illegal;
  logic [7:0] last_result;
  // reference state kept by the bench
  logic [7:0] m_acc;
  logic [7:0] m_last;
  logic [7:0] m_rf [128];
  sxs_flags_t m_fl;
  sxs_dirs_t  m_dir;
  int         n_fail;
  int         num_checks;

  sxs_exec uut (
    .clk          (clk),
    .reset_n      (reset_n),
    .clk_en       (clk_en),
    .req_valid    (req_valid),
    .req          (req),
    .wake_pin     (wake_pin),
    .wdt_enable   (wdt_enable),
    .acc_out      (acc_out),
    .flags_out    (flags_out),
    .dirs_out     (dirs_out),
    .wdt_count    (wdt_count),
    .wdt_prescale (wdt_prescale),
    .asleep       (asleep),
    .osc_run      (osc_run),
    .done         (done),
    .illegal      (illegal),
    .last_result  (last_result)
  );

  // 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // a - b - !cin as {carry, nibble carry, diff}; carry means no borrow
  function automatic logic [9:0] sub_calc(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, ~b} + 9'(cin);
    n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(cin);
    return {s[8], n[4], s[7:0]};
  endfunction

  task automatic chk_val(input string nm, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // present one request at a falling edge, update the reference, check after the next rising edge
  task automatic step(input sxs_op_t op, input logic [7:0] lit, input logic [6:0] fi, input logic d,
                      input logic en);
    logic [9:0] r;
    logic [7:0] f;
    logic [7:0] res;
    logic       ill;
    logic       calc;
    logic       lit_op;
    req_valid = 1'b1;
    req       = '{op: op, lit: lit, fidx: fi, dest: d};
    clk_en    = en;
    f         = m_rf[fi];
    r         = sub_calc(f, m_acc, (op == SXS_OP_REG_SUB) | m_fl.carry);
    res       = 8'h00;
    ill       = 1'b0;
    calc      = 1'b1;
    lit_op    = (op == SXS_OP_LIT_SUB) || (op == SXS_OP_LIT_XOR);
    case (op)
      SXS_OP_LIT_SUB: r = sub_calc(lit, m_acc, 1'b1);
      SXS_OP_REG_SUB, SXS_OP_REG_SUB_B: ;
      SXS_OP_NIB_EX: res = {f[3:0], f[7:4]};
      SXS_OP_LIT_XOR: res = m_acc ^ lit;
      SXS_OP_REG_XOR: res = m_acc ^ f;
      SXS_OP_NOP, SXS_OP_DIR_LOAD, SXS_OP_SLEEP: calc = 1'b0;
      default: begin
        calc = 1'b0;
        ill  = 1'b1;
      end
    endcase
    if (op inside {SXS_OP_LIT_SUB, SXS_OP_REG_SUB, SXS_OP_REG_SUB_B}) begin
      res = r[7:0];
    end
    if (op == SXS_OP_DIR_LOAD && !(fi inside {7'h05, 7'h06, 7'h07})) begin
      ill = 1'b1;
    end
    if (en) begin
      if (calc && op inside {SXS_OP_LIT_SUB, SXS_OP_REG_SUB, SXS_OP_REG_SUB_B}) begin
        m_fl.carry                 = r[9];
        m_fl.nibble_borrow_inverse = r[8];
      end
      // zero follows every result but the swap
      if (calc && op != SXS_OP_NIB_EX) begin
        m_fl.zero = (res == 8'h00);
      end
      if (calc) begin
        m_last = res;
        if (d && !lit_op) begin
          m_rf[fi] = res;
        end else begin
          m_acc = res;
        end
      end
      if (op == SXS_OP_DIR_LOAD && fi == 7'h05) m_dir.port_a_direction = m_acc;
      if (op == SXS_OP_DIR_LOAD && fi == 7'h06) m_dir.port_b_direction = m_acc;
      if (op == SXS_OP_DIR_LOAD && fi == 7'h07) m_dir.port_c_direction = m_acc;
      if (op == SXS_OP_SLEEP) begin
        m_fl.powerdown_flag_n = 1'b0;
        m_fl.timeout_flag_n   = 1'b1;
      end
    end
    @(negedge clk);
    chk_val("acc", 24'(m_acc), 24'(acc_out));
    chk_val("flags", 24'(m_fl), 24'(flags_out));
    chk_val("dirs", m_dir, dirs_out);
    chk_val("last_result", 24'(m_last), 24'(last_result));
    if (en) begin
      chk_bit("done", 1'b1, done);
      chk_bit("illegal", ill, illegal);
    end
  endtask

  initial begin
    logic [31:0] rv;
    sxs_op_t     op;
    clk_en     = 1'b1;
    req_valid  = 1'b0;
    req        = '0;
    wake_pin   = 1'b0;
    wdt_enable = 1'b0;
    reset_n    = 1'b0;
    n_fail     = 0;
    num_checks = 0;
    m_acc      = 8'h00;
    m_last     = 8'h00;
    m_fl       = '{carry: 1'b0, nibble_borrow_inverse: 1'b0, zero: 1'b0, timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};
    m_dir      = 24'hFFFFFF;
    foreach (m_rf[i]) m_rf[i] = 8'h00;
    void'($urandom(32'h33C5));
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk_val("reset flags", 24'(m_fl), 24'(flags_out));
    chk_val("reset dirs", m_dir, dirs_out);
    $display("test reset done");
    // hand-picked corners: walk case, equal operands, borrow chains, top index, all direction operands
    step(SXS_OP_LIT_XOR, 8'h03, 7'h00, 1'b0, 1'b1);
    step(SXS_OP_LIT_SUB, 8'h05, 7'h00, 1'b1, 1'b1);
    step(SXS_OP_LIT_SUB, 8'h02, 7'h00, 1'b0, 1'b1);
    step(SXS_OP_REG_SUB, 8'h00, 7'h7F, 1'b1, 1'b1);
    step(SXS_OP_REG_SUB_B, 8'h00, 7'h7F, 1'b0, 1'b1);
    step(SXS_OP_REG_XOR, 8'h00, 7'h7F, 1'b1, 1'b1);
    step(SXS_OP_NIB_EX, 8'h00, 7'h7F, 1'b0, 1'b1);
    step(SXS_OP_NOP, 8'hA5, 7'h7F, 1'b1, 1'b1);
    for (int k = 4; k <= 8; k++) begin
      step(SXS_OP_DIR_LOAD, 8'h00, 7'(k), 1'b0, 1'b1);
    end
    $display("test corners done");
    // random traffic on few indices so write-backs are read again; some frozen cycles
    repeat (600) begin
      rv = $urandom;
      op = sxs_op_t'(rv[3:0]);
      if (op == SXS_OP_NOP || op == SXS_OP_SLEEP) op = SXS_OP_REG_SUB_B;
      step(op, rv[15:8], (rv[16] ? 7'(rv[19:17]) : rv[26:20]), rv[27], (rv[30:28] != 3'h0));
    end
    $display("test random done");
    // watchdog runs 300 cycles, then sleep must clear it
    // the last random step may have left the clock enable low
    req_valid  = 1'b0;
    clk_en     = 1'b1;
    wdt_enable = 1'b1;
    repeat (300) @(negedge clk);
    chk_val("wdt", 24'h000001, 24'(wdt_count));
    chk_val("pre", 24'h00002C, 24'(wdt_prescale));
    // prescaler still counting at the sleep edge, so the clear must win
    step(SXS_OP_SLEEP, 8'h00, 7'h00, 1'b0, 1'b1);
    chk_val("wdt", 24'h000000, 24'(wdt_count));
    chk_val("pre", 24'h000000, 24'(wdt_prescale));
    wdt_enable = 1'b0;
    chk_bit("asleep", 1'b1, asleep);
    chk_bit("osc_run", 1'b0, osc_run);
    // a request while halted is ignored
    req = '{op: SXS_OP_LIT_XOR, lit: 8'hFF, fidx: 7'h00, dest: 1'b0};
    @(negedge clk);
    chk_val("acc", 24'(m_acc), 24'(acc_out));
    chk_bit("done", 1'b0, done);
    wake_pin = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit("asleep", 1'b1, asleep);
    @(negedge clk);
    chk_bit("asleep", 1'b0, asleep);
    chk_bit("osc_run", 1'b1, osc_run);
    wake_pin = 1'b0;
    step(SXS_OP_LIT_SUB, 8'h00, 7'h00, 1'b0, 1'b1);
    req_valid = 1'b0;
    $display("test sleep done");
    summarize();
  end
endmodule // tb_subtract_xor_swap_sleep_ops
`default_nettype wire
